// ### core/scg_clk_gate.sv
/*
 Glitch-free clock gate cell: latch the enable while the clock is low.
 Assumes the enable is driven from flops on the rising edge of clk_in.
*/
`timescale 1ns/1ps
`default_nettype none
module scg_clk_gate (
   // clock in
   input wire logic clk_in,
   // enable, registered
   input wire logic enable,
   // gated clock
   output logic clk_out
);
   logic en_latch;

   // transparent low latch keeps the gated pulse whole
   always_latch begin
      if (!clk_in) begin
         en_latch = enable; // R14
      end
   end

   assign clk_out = clk_in & en_latch;
endmodule : scg_clk_gate
`default_nettype wire

// ### core/scg_pkg.sv
/*
 Package for the sleep-mode clock gate block: register offsets, bit positions,
 reset values, power states and bus fault answers.
 Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
// Notes on behaviour
// R1 - gate bit one in active register: unit gets its clock
// R2 - gate bit zero in active register: unit clock withheld, unit disabled
// R3 - bus access to a unit whose clock is off answers with a fault
// R4 - reset clears all gate bits, every unit starts unclocked
// R5 - run register in run, sleep register in sleep, deep register in deep sleep
// R6 - sleep registers apply only when auto clock gating select is set
// R7 - bit 30 gates the Ethernet PHY clock
// R8 - bit 28 gates the Ethernet MAC clock
// R9 - bits 0 to 6 gate ports A to G
// R10 - bits 31, 29 and 27:7 read zero and ignore writes
// R11 - software keeps reserved bits across read-modify-write
// R12 - register decoded at offset 0x118 from base 0x400fe000
// R13 - software must enable each unit it needs during sleep
// R14 - enables change only on clean clock boundaries, no glitches
package scg_pkg;
   localparam logic [31:0] SCG_SYSCTL_BASE = 32'h400fe000;
   localparam logic [11:0] SCG_RUN_GATE_OFS = 12'h108;
   localparam logic [11:0] SCG_SLEEP_GATE_OFS = 12'h118;
   localparam logic [11:0] SCG_DEEP_GATE_OFS = 12'h128;
   localparam logic [11:0] SCG_CLK_CFG_OFS = 12'h060;
   localparam logic [11:0] SCG_STATUS_OFS = 12'h130;
   localparam int SCG_PHY_BIT = 30;
   localparam int SCG_MAC_BIT = 28;
   localparam int SCG_PORT_LSB = 0;
   localparam int SCG_NUM_PORTS = 7;
   localparam int SCG_ACG_BIT = 27;
   localparam logic [31:0] SCG_GATE_MASK = 32'h5000007f;
   localparam logic [31:0] SCG_GATE_RESET = 32'h00000000;
   localparam logic [31:0] SCG_CFG_RESET = 32'h00000000;
   localparam int SCG_NUM_UNITS = 9;
   localparam logic [1:0] SCG_RESP_OK = 2'h0;
   localparam logic [1:0] SCG_RESP_FAULT = 2'h2;
   localparam logic [1:0] SCG_RESP_DECERR = 2'h3;

   typedef enum logic [1:0] {
      SCG_PWR_RUN = 2'b00,
      SCG_PWR_SLEEP = 2'b01,
      SCG_PWR_DEEP = 2'b10
   } scg_pwr_t;

   // fold a 32-bit gate word into one enable per unit: ports A..G, MAC, PHY
   function automatic logic [8:0] scg_units(input logic [31:0] w);
      scg_units = {w[SCG_PHY_BIT], w[SCG_MAC_BIT], w[SCG_PORT_LSB +: SCG_NUM_PORTS]};
   endfunction : scg_units
endpackage : scg_pkg

// ### core/scg_top.sv
/*
 Sleep-mode clock gate control: run, sleep and deep-sleep gate registers, the
 clock configuration bit that enables the sleep registers, gated unit clocks
 and bus fault check for accesses to unclocked units.
 Assumes an Avalon-MM master on mclk; power state and unit access requests
 come from the system, synchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module scg_top #(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // avalon-mm register slave
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [1:0] avs_response,
   // power state from the system
   input wire scg_pkg::scg_pwr_t pwr_state,
   // peripheral access check
   input wire logic [scg_pkg::SCG_NUM_UNITS-1:0] unit_access,
   output logic [scg_pkg::SCG_NUM_UNITS-1:0] unit_fault,
   // unit clock enables and gated clocks
   output logic [scg_pkg::SCG_NUM_UNITS-1:0] unit_clk_en,
   output logic [scg_pkg::SCG_NUM_UNITS-1:0] unit_clk
);
   import scg_pkg::*;

   logic [31:0] run_clock_gate_ctrl_2_q, run_clock_gate_ctrl_2_d;
   logic [31:0] sleep_clock_gate_ctrl_2_q, sleep_clock_gate_ctrl_2_d;
   logic [31:0] deep_sleep_clock_gate_ctrl_2_q, deep_sleep_clock_gate_ctrl_2_d;
   logic [31:0] run_clock_config_reg_q, run_clock_config_reg_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] resp_q, resp_d;
   logic wait_q, wait_d;
   logic [SCG_NUM_UNITS-1:0] en_q, en_d;
   logic [SCG_NUM_UNITS-1:0] fault_q, fault_d;
   logic auto_clock_gating_sel;
   logic req;
   logic [31:0] be_mask;

   // expand byte enables to a bit mask
   function automatic logic [31:0] be_bits(input logic [3:0] be);
      be_bits = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction : be_bits

   // merge write data into a register, keeping unwritten lanes and reserved bits
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [31:0] bm, input logic [31:0] keep);
      merge = (old & ~(bm & keep)) | (wd & bm & keep);
   endfunction : merge

   assign auto_clock_gating_sel = run_clock_config_reg_q[SCG_ACG_BIT];
   assign req = (avs_read | avs_write) & wait_q;
   assign be_mask = be_bits(avs_byteenable);

   // register file: one wait cycle, then an answer with waitrequest low
   always_comb begin
      run_clock_gate_ctrl_2_d = run_clock_gate_ctrl_2_q;
      sleep_clock_gate_ctrl_2_d = sleep_clock_gate_ctrl_2_q;
      deep_sleep_clock_gate_ctrl_2_d = deep_sleep_clock_gate_ctrl_2_q;
      run_clock_config_reg_d = run_clock_config_reg_q;
      rdata_d = 32'h00000000;
      resp_d = SCG_RESP_OK;
      wait_d = ~req; // low for the one answer cycle after a taken request
      if (req) begin
         unique case (avs_address)
            SCG_RUN_GATE_OFS: begin
               rdata_d = run_clock_gate_ctrl_2_q;
               if (avs_write) begin
                  run_clock_gate_ctrl_2_d = merge(run_clock_gate_ctrl_2_q, avs_writedata,
                                                  be_mask, SCG_GATE_MASK); // R10
               end
            end
            SCG_SLEEP_GATE_OFS: begin // R12
               rdata_d = sleep_clock_gate_ctrl_2_q; // R10
               if (avs_write) begin
                  sleep_clock_gate_ctrl_2_d = merge(sleep_clock_gate_ctrl_2_q, avs_writedata,
                                                    be_mask, SCG_GATE_MASK); // R7 R8 R9 R10
               end
            end
            SCG_DEEP_GATE_OFS: begin
               rdata_d = deep_sleep_clock_gate_ctrl_2_q;
               if (avs_write) begin
                  deep_sleep_clock_gate_ctrl_2_d = merge(deep_sleep_clock_gate_ctrl_2_q,
                                                         avs_writedata, be_mask, SCG_GATE_MASK);
               end
            end
            SCG_CLK_CFG_OFS: begin
               rdata_d = run_clock_config_reg_q;
               if (avs_write) begin
                  run_clock_config_reg_d = merge(run_clock_config_reg_q, avs_writedata,
                                                 be_mask, 32'h00000001 << SCG_ACG_BIT);
               end
            end
            SCG_STATUS_OFS: begin
               rdata_d = {{(32-SCG_NUM_UNITS){1'b0}}, en_q}; // live enables, read-only
            end
            default: begin
               resp_d = SCG_RESP_DECERR; // unmapped address
            end
         endcase
      end
   end

   // register file flops
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         run_clock_gate_ctrl_2_q <= SCG_GATE_RESET;
         sleep_clock_gate_ctrl_2_q <= SCG_GATE_RESET; // R4
         deep_sleep_clock_gate_ctrl_2_q <= SCG_GATE_RESET;
         run_clock_config_reg_q <= SCG_CFG_RESET;
         rdata_q <= 32'h00000000;
         resp_q <= SCG_RESP_OK;
         wait_q <= 1'b1; // idle: nothing answered yet
      end else begin
         run_clock_gate_ctrl_2_q <= run_clock_gate_ctrl_2_d;
         sleep_clock_gate_ctrl_2_q <= sleep_clock_gate_ctrl_2_d;
         deep_sleep_clock_gate_ctrl_2_q <= deep_sleep_clock_gate_ctrl_2_d;
         run_clock_config_reg_q <= run_clock_config_reg_d;
         rdata_q <= rdata_d;
         resp_q <= resp_d;
         wait_q <= wait_d;
      end
   end

   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;
   assign avs_response = resp_q;

   // pick the gate source by power state; sleep registers need auto gating
   always_comb begin
      en_d = scg_units(run_clock_gate_ctrl_2_q);
      if (auto_clock_gating_sel) begin // R6
         unique case (pwr_state)
            SCG_PWR_SLEEP: en_d = scg_units(sleep_clock_gate_ctrl_2_q); // R5
            SCG_PWR_DEEP: en_d = scg_units(deep_sleep_clock_gate_ctrl_2_q); // R5
            default: en_d = scg_units(run_clock_gate_ctrl_2_q); // R5
         endcase
      end
      fault_d = unit_access & ~en_q; // R3
   end

   // enables and fault flags registered on the rising edge
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         en_q <= '0;
         fault_q <= '0;
      end else begin
         en_q <= en_d;
         fault_q <= fault_d;
      end
   end

   assign unit_clk_en = en_q;
   assign unit_fault = fault_q;

   // one glitch-free gate per unit
   generate
      for (genvar i = 0; i < SCG_NUM_UNITS; i++) begin : g_gate
         scg_clk_gate u_gate (
            .clk_in(mclk),
            .enable(en_q[i]), // R1 R2
            .clk_out(unit_clk[i]) // R14
         );
      end
   endgenerate
endmodule : scg_top
`default_nettype wire

// ### dv/scg_chk_assertions.sv
/* checker for the sleep clock gate block ports
   assumes binding into scg_top and a single mclk domain */
`timescale 1ns/1ps
`default_nettype none
module scg_chk #(parameter int ADDR_W = 12) (
   // clock, reset and bus
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [1:0] avs_response,
   // power state and units
   input wire scg_pkg::scg_pwr_t pwr_state,
   input wire logic [8:0] unit_access,
   input wire logic [8:0] unit_fault,
   input wire logic [8:0] unit_clk_en,
   input wire logic [8:0] unit_clk
);
   import scg_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // bus answers and decoded values
   wait_ans_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered");
   wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer held too long");
   sleep_rd_a: assert property (avs_read && !avs_waitrequest && avs_address == SCG_SLEEP_GATE_OFS
      |-> avs_response == SCG_RESP_OK && (avs_readdata & ~SCG_GATE_MASK) == 32'h0)
      else $error("reserved bits not zero");
   unmapped_a: assert property (!avs_waitrequest && avs_response == SCG_RESP_DECERR
      |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
   // enables, faults and gated clocks
   rst_clear_a: assert property ($rose(reset_n) |-> unit_clk_en == 9'h0)
      else $error("enables not cleared");
   fault_map_a: assert property (1'b1 |=> unit_fault == $past(unit_access & ~unit_clk_en))
      else $error("fault mismatch");
   en_change_a: assert property ($changed(unit_clk_en) |-> $past(avs_write && !avs_waitrequest)
      || $past(pwr_state) != $past(pwr_state, 2)) else $error("enable changed without cause");
   clk_low_a: assert property (unit_clk == 9'h0)
      else $error("gated clock high while mclk low");
   // high phase shows the enable latched in the low phase before it
   gate_on_a: assert property (@(negedge mclk) unit_clk == $past(unit_clk_en))
      else $error("gated clock does not follow its enable");
   cover property (avs_write && !avs_waitrequest);
   cover property (unit_fault != 9'h0);
   cover property (!avs_waitrequest && avs_response == SCG_RESP_DECERR);
   cover property (pwr_state == SCG_PWR_SLEEP && unit_clk_en != 9'h0);
endmodule : scg_chk
bind scg_top scg_chk #(.ADDR_W(ADDR_W)) u_scg_chk (.mclk, .reset_n, .avs_address, .avs_read,
   .avs_write, .avs_readdata, .avs_waitrequest, .avs_response, .pwr_state, .unit_access,
   .unit_fault, .unit_clk_en, .unit_clk);
`default_nettype wire

// ### dv/tb_top.sv
/* self-checking bench for the sleep clock gate block
   assumes scg_top with its checker bound in */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import scg_pkg::*;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic [11:0] avs_address = 12'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata, r, s, d;
   logic avs_waitrequest;
   logic [1:0] avs_response;
   scg_pwr_t pwr_state = SCG_PWR_RUN;
   logic [8:0] unit_access = 9'h0;
   logic [8:0] unit_fault, unit_clk_en, unit_clk, ex;
   logic [33:0] expq[$];
   int errors = 0;
   int checked = 0;
   int cyc = 0;
   scg_top u_scg_top (.mclk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response, .pwr_state,
      .unit_access, .unit_fault, .unit_clk_en, .unit_clk);
   // clock and hang limit
   always #12.5 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         errors++;
         end_sim();
      end
   end
   // bus answers compared against the oldest note
   always @(posedge mclk) begin
      if ((avs_read || avs_write) && avs_waitrequest === 1'b0) begin
         if (expq.size() == 0) begin
            errors++;
            $display("CHECK FAILED answer exp none got %h", avs_response);
         end else begin
            if (avs_read) chk("rdata", expq[0][31:0], avs_readdata);
            chk("resp", {30'h0, expq[0][33:32]}, {30'h0, avs_response});
            void'(expq.pop_front());
         end
      end
   end
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask : chk
   // one bus access; for reads v is the expected data, rsp the expected answer
   task automatic xfer(logic w, logic [11:0] a, logic [31:0] v, logic [1:0] rsp = SCG_RESP_OK);
      expq.push_back({rsp, v});
      avs_read <= !w;
      avs_write <= w;
      avs_address <= a;
      avs_writedata <= v;
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge mclk);
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge mclk); // request low for one edge between accesses
   endtask : xfer
   function automatic logic [8:0] u9(logic [31:0] w);
      return {w[30], w[28], w[6:0]};
   endfunction : u9
   // main sequence
   initial begin
      void'($urandom(32'h6254));
      for (int k = 0; k < 2; k++) begin
         reset_n <= 1'b0;
         repeat (12) @(posedge mclk);
         reset_n <= 1'b1;
         @(posedge mclk);
         xfer(1'b0, SCG_SLEEP_GATE_OFS, 32'h0);
         chk("en", 32'h0, {23'h0, unit_clk_en});
         xfer(1'b1, SCG_SLEEP_GATE_OFS, 32'hffffffff);
         xfer(1'b0, SCG_SLEEP_GATE_OFS, SCG_GATE_MASK);
      end
      $display("test reset and reserved done");
      for (int i = 0; i < 4; i++) begin
         s = $urandom();
         xfer(1'b1, SCG_SLEEP_GATE_OFS, s);
         xfer(1'b0, SCG_SLEEP_GATE_OFS, s & SCG_GATE_MASK);
      end
      // low byte lane only: upper lanes keep their gates
      avs_byteenable <= 4'h1;
      xfer(1'b1, SCG_SLEEP_GATE_OFS, ~s);
      avs_byteenable <= 4'hf;
      s = {s[31:8], ~s[7:0]} & SCG_GATE_MASK;
      xfer(1'b0, SCG_SLEEP_GATE_OFS, s);
      // read-modify-write keeps the reserved bits as read
      s = s | (32'h1 << SCG_MAC_BIT);
      xfer(1'b1, SCG_SLEEP_GATE_OFS, s);
      xfer(1'b0, SCG_SLEEP_GATE_OFS, s);
      xfer(1'b1, 12'h3fc, s, SCG_RESP_DECERR);
      xfer(1'b0, 12'h3fc, 32'h0, SCG_RESP_DECERR);
      $display("test map done");
      r = $urandom();
      d = $urandom();
      xfer(1'b1, SCG_RUN_GATE_OFS, r);
      xfer(1'b1, SCG_DEEP_GATE_OFS, d);
      xfer(1'b0, SCG_RUN_GATE_OFS, r & SCG_GATE_MASK);
      xfer(1'b0, SCG_DEEP_GATE_OFS, d & SCG_GATE_MASK);
      for (int c = 0; c < 2; c++) begin
         xfer(1'b1, SCG_CLK_CFG_OFS, 32'(c) << SCG_ACG_BIT);
         xfer(1'b0, SCG_CLK_CFG_OFS, 32'(c) << SCG_ACG_BIT);
         for (int p = 0; p < 4; p++) begin
            pwr_state <= scg_pwr_t'(p[1:0]);
            repeat (3) @(posedge mclk);
            ex = (c == 1 && p == 1) ? u9(s) : (c == 1 && p == 2) ? u9(d) : u9(r);
            chk("en", {23'h0, ex}, {23'h0, unit_clk_en});
            unit_access <= 9'h1ff;
            @(posedge mclk);
            #1;
            chk("fault", {23'h0, ~ex}, {23'h0, unit_fault});
            chk("clk", {23'h0, ex}, {23'h0, unit_clk});
            @(posedge mclk);
            unit_access <= 9'h0;
         end
      end
      xfer(1'b0, SCG_STATUS_OFS, {23'h0, u9(r)});
      $display("test gating done");
      end_sim();
   end
   task automatic end_sim();
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim
endmodule : tb_top
`default_nettype wire
